/* File: logic/csp_pkg.sv */
// Package with register map, field positions, reset values and state encodings of the clock config port.
package csp_pkg;

  // Register indices, one byte each.
  localparam logic [7:0] OFS_OUT_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_SPREAD_SWING = 8'h01;
  localparam logic [7:0] OFS_BYTE_COUNT   = 8'h07;

  // Field positions inside the output enable byte.
  localparam int BIT_OE1 = 2;
  localparam int BIT_OE0 = 1;

  // Field positions inside the spread and swing byte.
  localparam int RB_HI      = 7;
  localparam int RB_LO      = 6;
  localparam int BIT_SW_OVR = 5;
  localparam int SW_AMT_HI  = 4;
  localparam int SW_AMT_LO  = 3;
  localparam int AMP_HI     = 1;
  localparam int AMP_LO     = 0;

  // Field position of the readback count.
  localparam int CNT_HI = 4;

  // Reset values.
  localparam logic       RST_OE     = 1'b1;
  localparam logic       RST_SW_OVR = 1'b0;
  localparam logic [1:0] RST_SW_AMT = 2'h0;
  localparam logic [1:0] RST_AMP    = 2'h2;
  localparam logic [4:0] RST_COUNT  = 5'h08;

  // Read values of reserved bits and of unmapped bytes.
  localparam logic [4:0] OE_RSV_HI   = 5'h1F;
  localparam logic       OE_RSV_LO   = 1'b1;
  localparam logic       SS_RSV_BIT  = 1'b1;
  localparam logic [2:0] CNT_RSV_HI  = 3'h0;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Bus addresses for the two strap settings; the values are arbitrary.
  localparam logic [6:0] ADDR_STRAP0 = 7'h50;
  localparam logic [6:0] ADDR_STRAP1 = 7'h52;

  // Bits of one byte on the wire.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Bus phase; Gray steps along address, receive and transmit paths.
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RX       = 3'h2,
    ST_RX_ACK   = 3'h6,
    ST_TX       = 3'h7,
    ST_TX_ACK   = 3'h5,
    ST_IGNORE   = 3'h4
  } csp_state_e;

  // Meaning of the next byte received in a write.
  typedef enum logic [1:0] {
    ROLE_INDEX = 2'h0,
    ROLE_COUNT = 2'h1,
    ROLE_DATA  = 2'h3
  } csp_role_e;

endpackage

/* File: logic/csp_line_if.sv */
// Interface carrying one filtered bus line with its edge pulses.
interface csp_line_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* File: logic/csp_pin_filter.sv */
// Three-flop synchroniser and agreement filter for one bus pin.
module csp_pin_filter #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  input  wire logic   pin,
  csp_line_if.src     line
);

  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic rise_ff;
  logic fall_ff;
  wire  agree;
  wire  nxt_level;

  // A change counts only once the second and third stages agree.
  assign agree     = (sync2_ff == sync3_ff);
  assign nxt_level = agree ? sync3_ff : level_ff;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_ff <= RESET_LEVEL;
      sync2_ff <= RESET_LEVEL;
      sync3_ff <= RESET_LEVEL;
      level_ff <= RESET_LEVEL;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end
    else if (ce)
    begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
      rise_ff  <= nxt_level & ~level_ff;
      fall_ff  <= ~nxt_level & level_ff;
    end
  end

  // Edge pulses line up with the cycle in which the level changes.
  assign line.level = level_ff;
  assign line.rise  = rise_ff;
  assign line.fall  = fall_ff;

endmodule // csp_pin_filter

/* File: logic/csp_smbus_port.sv */
// Top of the clock config port: bus target, control bytes and output controls.

// How it works
// - Acknowledge address, index, count, every data byte.
// - Read returns byte count first, then bytes.
// - Answer only the strap-selected address.
// - Enable byte bits 2,1 enable outputs.
// - Spread byte bits 7:6 read latched pin.
// - Override bit chooses pin or software spread.
// - Software spread field codes, default off.
// - Bits 1:0 select amplitude, default 10.
// - Writable readback count, default eight bytes.
module csp_smbus_port (
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  input  wire logic       CE,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       ADDR_SELECT_STRAP,
  input  wire logic [1:0] SPREAD_PIN_LEVEL,
  output logic            DIFF_OUT1_ENABLE,
  output logic            DIFF_OUT0_ENABLE,
  output logic [1:0]      SPREAD_AMOUNT,
  output logic [1:0]      AMPLITUDE_SEL
);

  csp_line_if scl ();
  csp_line_if sda ();

  csp_pkg::csp_state_e state_ff;
  csp_pkg::csp_state_e nxt_state;
  csp_pkg::csp_role_e  role_ff;
  csp_pkg::csp_role_e  nxt_role;
  logic [3:0]          bit_cnt_ff;
  logic [3:0]          nxt_bit_cnt;
  logic [7:0]          shreg_ff;
  logic [7:0]          nxt_shreg;
  logic [7:0]          index_ff;
  logic [7:0]          nxt_index;
  logic [7:0]          wr_left_ff;
  logic [7:0]          nxt_wr_left;
  logic                sda_oe_ff;
  logic                nxt_sda_oe;
  logic                is_read_ff;
  logic                nxt_is_read;
  logic                nack_ff;
  logic                nxt_nack;
  logic                sda_out_ff;
  logic                straps_taken_ff;
  logic                addr_strap_ff;
  logic [1:0]          pin_rb_ff;
  logic                sw_ovr_ff;
  logic [1:0]          sw_amt_ff;
  logic [4:0]          count_ff;
  logic                oe1_ff;
  logic                oe0_ff;
  logic [1:0]          amp_ff;
  logic [1:0]          spread_eff_ff;

  csp_pin_filter #(.RESET_LEVEL(1'b1)) u_scl_filter (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .ce   (CE),
    .pin  (SCL_IN),
    .line (scl)
  );

  csp_pin_filter #(.RESET_LEVEL(1'b1)) u_sda_filter (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .ce   (CE),
    .pin  (SDA_IN),
    .line (sda)
  );

  // Bus conditions and byte decode.
  wire       start_cond = sda.fall & scl.level;
  wire       stop_cond  = sda.rise & scl.level;
  wire       byte_done  = (bit_cnt_ff == csp_pkg::BITS_PER_BYTE);
  wire [6:0] my_addr    = addr_strap_ff ? csp_pkg::ADDR_STRAP1 : csp_pkg::ADDR_STRAP0;
  wire       addr_hit   = (shreg_ff[7:1] == my_addr);
  wire       byte_end   = scl.fall & byte_done;
  wire       wr_strobe  = (state_ff == csp_pkg::ST_RX) & byte_end & (role_ff == csp_pkg::ROLE_DATA)
                          & (wr_left_ff != 8'h00);
  wire       wr_oe      = wr_strobe & (index_ff == csp_pkg::OFS_OUT_ENABLE);
  wire       wr_ss      = wr_strobe & (index_ff == csp_pkg::OFS_SPREAD_SWING);
  wire       wr_cnt     = wr_strobe & (index_ff == csp_pkg::OFS_BYTE_COUNT);

  // Read view of each byte; reserved bits read as their defaults.
  wire [7:0] rd_oe    = {csp_pkg::OE_RSV_HI, oe1_ff, oe0_ff, csp_pkg::OE_RSV_LO};
  wire [7:0] rd_ss    = {pin_rb_ff, sw_ovr_ff, sw_amt_ff, csp_pkg::SS_RSV_BIT, amp_ff};
  wire [7:0] rd_cnt   = {csp_pkg::CNT_RSV_HI, count_ff};
  wire [7:0] rd_byte  = (index_ff == csp_pkg::OFS_OUT_ENABLE)   ? rd_oe :
                        (index_ff == csp_pkg::OFS_SPREAD_SWING) ? rd_ss :
                        (index_ff == csp_pkg::OFS_BYTE_COUNT)   ? rd_cnt : csp_pkg::UNMAPPED_RD;

  // Bus phase sequencing; a stop or start overrides whatever phase is running.
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_role    = role_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shreg   = shreg_ff;
    nxt_index   = index_ff;
    nxt_wr_left = wr_left_ff;
    nxt_sda_oe  = sda_oe_ff;
    nxt_is_read = is_read_ff;
    nxt_nack    = nack_ff;
    if (stop_cond)
    begin
      nxt_state  = csp_pkg::ST_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else if (start_cond)
    begin
      nxt_state   = csp_pkg::ST_ADDR;
      nxt_role    = csp_pkg::ROLE_INDEX;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe  = 1'b0;
    end
    else
    begin
      case (state_ff)
        csp_pkg::ST_ADDR, csp_pkg::ST_RX:
        begin
          if (scl.rise)
          begin
            nxt_shreg   = {shreg_ff[6:0], sda.level};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          if (byte_end && state_ff == csp_pkg::ST_ADDR)
          begin
            nxt_state   = addr_hit ? csp_pkg::ST_ADDR_ACK : csp_pkg::ST_IGNORE;
            nxt_sda_oe  = addr_hit;
            nxt_is_read = shreg_ff[0];
          end
          else if (byte_end)
          begin
            nxt_state  = csp_pkg::ST_RX_ACK;
            nxt_sda_oe = 1'b1;
            case (role_ff)
              csp_pkg::ROLE_INDEX:
              begin
                nxt_index = shreg_ff;
                nxt_role  = csp_pkg::ROLE_COUNT;
              end
              csp_pkg::ROLE_COUNT:
              begin
                nxt_wr_left = shreg_ff;
                nxt_role    = csp_pkg::ROLE_DATA;
              end
              default:
              begin
                if (wr_left_ff != 8'h00)
                begin
                  nxt_wr_left = wr_left_ff - 8'h01;
                  nxt_index   = index_ff + 8'h01;
                end
              end
            endcase
          end
        end
        csp_pkg::ST_ADDR_ACK:
        begin
          if (scl.fall)
          begin
            nxt_bit_cnt = 4'h0;
            if (is_read_ff)
            begin
              nxt_state  = csp_pkg::ST_TX;
              nxt_shreg  = rd_cnt;
              nxt_sda_oe = ~rd_cnt[7];
            end
            else
            begin
              nxt_state  = csp_pkg::ST_RX;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        csp_pkg::ST_RX_ACK:
        begin
          if (scl.fall)
          begin
            nxt_state   = csp_pkg::ST_RX;
            nxt_bit_cnt = 4'h0;
            nxt_sda_oe  = 1'b0;
          end
        end
        csp_pkg::ST_TX:
        begin
          if (scl.rise)
          begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          if (byte_end)
          begin
            nxt_state  = csp_pkg::ST_TX_ACK;
            nxt_sda_oe = 1'b0;
          end
          else if (scl.fall)
          begin
            nxt_sda_oe = ~shreg_ff[6];
            nxt_shreg  = {shreg_ff[6:0], 1'b0};
          end
        end
        csp_pkg::ST_TX_ACK:
        begin
          if (scl.rise)
          begin
            nxt_nack = sda.level;
          end
          if (scl.fall && nack_ff)
          begin
            nxt_state = csp_pkg::ST_IGNORE;
          end
          else if (scl.fall)
          begin
            nxt_state   = csp_pkg::ST_TX;
            nxt_shreg   = rd_byte;
            nxt_sda_oe  = ~rd_byte[7];
            nxt_index   = index_ff + 8'h01;
            nxt_bit_cnt = 4'h0;
          end
        end
        csp_pkg::ST_IDLE, csp_pkg::ST_IGNORE:
        begin
          nxt_sda_oe = 1'b0;
        end
        default:
        begin
          nxt_state  = csp_pkg::ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Bus state registers.
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      state_ff   <= csp_pkg::ST_IDLE;
      role_ff    <= csp_pkg::ROLE_INDEX;
      bit_cnt_ff <= 4'h0;
      shreg_ff   <= 8'h00;
      index_ff   <= 8'h00;
      wr_left_ff <= 8'h00;
      sda_oe_ff  <= 1'b0;
      is_read_ff <= 1'b0;
      nack_ff    <= 1'b0;
      sda_out_ff <= 1'b0;
    end
    else if (CE)
    begin
      state_ff   <= nxt_state;
      role_ff    <= nxt_role;
      bit_cnt_ff <= nxt_bit_cnt;
      shreg_ff   <= nxt_shreg;
      index_ff   <= nxt_index;
      wr_left_ff <= nxt_wr_left;
      sda_oe_ff  <= nxt_sda_oe;
      is_read_ff <= nxt_is_read;
      nack_ff    <= nxt_nack;
    end
  end

  // Straps are static pins caught once just after reset, so no synchroniser is spent on them.
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      straps_taken_ff <= 1'b0;
      addr_strap_ff   <= 1'b0;
      pin_rb_ff       <= 2'h0;
    end
    else if (CE && !straps_taken_ff)
    begin
      straps_taken_ff <= 1'b1;
      addr_strap_ff   <= ADDR_SELECT_STRAP;
      pin_rb_ff       <= SPREAD_PIN_LEVEL;
    end
  end

  // Control bytes; the effective spread is re-registered so the output stays a flop.
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      oe1_ff        <= csp_pkg::RST_OE;
      oe0_ff        <= csp_pkg::RST_OE;
      sw_ovr_ff     <= csp_pkg::RST_SW_OVR;
      sw_amt_ff     <= csp_pkg::RST_SW_AMT;
      amp_ff        <= csp_pkg::RST_AMP;
      count_ff      <= csp_pkg::RST_COUNT;
      spread_eff_ff <= 2'h0;
    end
    else if (CE)
    begin
      if (wr_oe)
      begin
        oe1_ff <= shreg_ff[csp_pkg::BIT_OE1];
        oe0_ff <= shreg_ff[csp_pkg::BIT_OE0];
      end
      if (wr_ss)
      begin
        sw_ovr_ff <= shreg_ff[csp_pkg::BIT_SW_OVR];
        sw_amt_ff <= shreg_ff[csp_pkg::SW_AMT_HI:csp_pkg::SW_AMT_LO];
        amp_ff    <= shreg_ff[csp_pkg::AMP_HI:csp_pkg::AMP_LO];
      end
      if (wr_cnt)
      begin
        count_ff <= shreg_ff[csp_pkg::CNT_HI:0];
      end
      spread_eff_ff <= sw_ovr_ff ? sw_amt_ff : pin_rb_ff;
    end
  end

  // Open-drain data pin: the output level is always low, only the enable moves.
  assign SDA_OUT          = sda_out_ff;
  assign SDA_OE           = sda_oe_ff;
  assign DIFF_OUT1_ENABLE = oe1_ff;
  assign DIFF_OUT0_ENABLE = oe0_ff;
  assign SPREAD_AMOUNT    = spread_eff_ff;
  assign AMPLITUDE_SEL    = amp_ff;

  // Checks on the bus phases and control outputs.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_addr_end;
    CE && state_ff == csp_pkg::ST_ADDR && byte_end && !start_cond && !stop_cond;
  endsequence
  sequence s_nack_end;
    CE && state_ff == csp_pkg::ST_TX_ACK && nack_ff && scl.fall && !start_cond && !stop_cond;
  endsequence

  property p_addr_ack;
    (s_addr_end and addr_hit) |=> (state_ff == csp_pkg::ST_ADDR_ACK) && sda_oe_ff;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged.");
  property p_addr_ignore;
    (s_addr_end and !addr_hit) |=> (state_ff == csp_pkg::ST_IGNORE) && !sda_oe_ff;
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("Foreign address answered.");
  property p_count_first;
    (CE && state_ff == csp_pkg::ST_ADDR_ACK && scl.fall && is_read_ff && !start_cond && !stop_cond)
      |=> (state_ff == csp_pkg::ST_TX) && (shreg_ff == {csp_pkg::CNT_RSV_HI, count_ff});
  endproperty
  a_count_first: assert property (p_count_first) else $error("Read did not open with count.");
  property p_rx_ack;
    (CE && state_ff == csp_pkg::ST_RX && byte_end && !start_cond && !stop_cond)
      |=> (state_ff == csp_pkg::ST_RX_ACK) && sda_oe_ff;
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("Received byte not acknowledged.");
  property p_store_oe;
    (CE && wr_oe) |=> (DIFF_OUT1_ENABLE == $past(shreg_ff[csp_pkg::BIT_OE1]))
      && (DIFF_OUT0_ENABLE == $past(shreg_ff[csp_pkg::BIT_OE0]));
  endproperty
  a_store_oe: assert property (p_store_oe) else $error("Output enables not stored.");
  property p_spread_pin;
    (CE && !sw_ovr_ff) |=> (SPREAD_AMOUNT == $past(pin_rb_ff));
  endproperty
  a_spread_pin: assert property (p_spread_pin) else $error("Spread not locked to pin.");
  property p_spread_sw;
    (CE && sw_ovr_ff) |=> (SPREAD_AMOUNT == $past(sw_amt_ff));
  endproperty
  a_spread_sw: assert property (p_spread_sw) else $error("Software spread not applied.");
  property p_readback_hold;
    straps_taken_ff |=> $stable(pin_rb_ff) && $stable(addr_strap_ff);
  endproperty
  a_readback_hold: assert property (p_readback_hold) else $error("Latched strap changed.");
  property p_amp_default;
    $fell(RESET) |-> (AMPLITUDE_SEL == csp_pkg::RST_AMP);
  endproperty
  a_amp_default: assert property (p_amp_default) else $error("Amplitude reset value wrong.");
  property p_count_default;
    $fell(RESET) |-> (count_ff == csp_pkg::RST_COUNT);
  endproperty
  a_count_default: assert property (p_count_default) else $error("Byte count reset value wrong.");
  property p_nack_end;
    s_nack_end |=> (state_ff == csp_pkg::ST_IGNORE) && !sda_oe_ff;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("Transmit went on after not-acknowledge.");

endmodule // csp_smbus_port

/* File: verif/csp_host_model.sv */
// Behavioural SMBus host controller that drives the bus clock and data lines of the port.
module csp_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_drv,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both lines idle released; the pull-up makes them read high.
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // Lines change on falling edges only, so nothing moves at the port's sampling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start and repeated start: data falls while the clock is high, phases well above the filter delay.
  task automatic start();
    tick(5);
    sda_drv = 1'b1;
    tick(5);
    scl_drv = 1'b1;
    tick(10);
    sda_drv = 1'b0;
    tick(10);
    scl_drv = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    tick(5);
    sda_drv = 1'b0;
    tick(5);
    scl_drv = 1'b1;
    tick(10);
    sda_drv = 1'b1;
    tick(10);
  endtask

  // One bit: data set mid low phase, wire sampled mid high phase; a 1 releases the line.
  task automatic bit_io(input logic b, output logic v);
    tick(5);
    sda_drv = b;
    tick(5);
    scl_drv = 1'b1;
    tick(5);
    v = sda_line;
    tick(5);
    scl_drv = 1'b0;
  endtask

  // One byte, most significant bit first.
  task automatic byte_io(input logic [7:0] b, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], v[i]);
  endtask

  // Block write of n data bytes; acks holds one bit per byte sent, address first.
  task automatic write_block(input logic [6:0] addr, input logic [7:0] idx, input logic [7:0] cnt,
                             input logic [15:0] d, input int n, output logic [4:0] acks);
    logic [7:0] b [0:4];
    logic [7:0] v;
    logic       a;
    b = '{{addr, 1'b0}, idx, cnt, d[15:8], d[7:0]};
    acks = 5'h00;
    start();
    for (int k = 0; k < 3 + n; k++)
    begin
      byte_io(b[k], v);
      bit_io(1'b1, a);
      acks[k] = ~a;
    end
    stop();
  endtask

  // Block read of n bytes; every byte but the last is acknowledged, the last gets a not-acknowledge.
  task automatic read_block(input logic [6:0] addr, input logic [7:0] idx, input int n,
                            output logic [31:0] q, output logic [2:0] acks);
    logic [7:0] v;
    logic       a;
    q = 32'h0;
    start();
    byte_io({addr, 1'b0}, v);
    bit_io(1'b1, a);
    acks[0] = ~a;
    byte_io(idx, v);
    bit_io(1'b1, a);
    acks[1] = ~a;
    start();
    byte_io({addr, 1'b1}, v);
    bit_io(1'b1, a);
    acks[2] = ~a;
    for (int k = 0; k < n; k++)
    begin
      byte_io(8'hFF, v);
      q = {q[23:0], v};
      bit_io(k == n - 1, a);
    end
    stop();
  endtask
endmodule // csp_host_model

/* File: verif/csp_smbus_port_test.sv */
// Self-checking bench of the clock config port: control writes, block reads, address strap and reset.
module csp_smbus_port_test;
  timeunit 1ns;
  timeprecision 1ns;

  // One control write with the outputs and readback byte it should give.
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
    logic [1:0] oe;
    logic [1:0] amp;
    logic [1:0] spread;
    logic [7:0] rd;
  } csp_row_s;

  localparam csp_row_s ROWS [0:7] = '{
    '{8'h00, 8'h02, 2'h1, 2'h2, 2'h3, 8'hFB}, '{8'h00, 8'h04, 2'h2, 2'h2, 2'h3, 8'hFD},
    '{8'h01, 8'h00, 2'h2, 2'h0, 2'h3, 8'hC4}, '{8'h01, 8'h21, 2'h2, 2'h1, 2'h0, 8'hE5},
    '{8'h01, 8'h2A, 2'h2, 2'h2, 2'h1, 8'hEE}, '{8'h01, 8'h3B, 2'h2, 2'h3, 2'h3, 8'hFF},
    '{8'h01, 8'h32, 2'h2, 2'h2, 2'h2, 8'hF6}, '{8'h01, 8'h18, 2'h2, 2'h0, 2'h3, 8'hDC}};
  localparam logic [6:0] A0 = csp_pkg::ADDR_STRAP0;
  localparam logic [6:0] A1 = csp_pkg::ADDR_STRAP1;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        strap = 1'b1;
  logic [1:0]  pin = 2'h3;
  logic        scl;
  logic        sda_host;
  logic        sda_oe;
  logic        sda_out;
  logic        oe1;
  logic        oe0;
  logic [1:0]  spread;
  logic [1:0]  amp;
  logic [4:0]  wacks;
  logic [2:0]  racks;
  logic [31:0] q;
  int          err_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  // Open-drain data wire: the pull-up wins unless a party pulls low.
  wire sda_wire = sda_host & ~sda_oe;

  always #10 clk = ~clk;

  csp_smbus_port i_csp_smbus_port (
    .CLK_SYS(clk), .RESET(rst), .CE(ce), .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDR_SELECT_STRAP(strap), .SPREAD_PIN_LEVEL(pin), .DIFF_OUT1_ENABLE(oe1),
    .DIFF_OUT0_ENABLE(oe0), .SPREAD_AMOUNT(spread), .AMPLITUDE_SEL(amp));

  csp_host_model i_csp_host_model (.clk(clk), .sda_line(sda_wire), .scl_drv(scl), .sda_drv(sda_host));

  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Straps are caught just after release, so they are set before reset ends.
  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  // Defaults of both control bytes, the count byte and an unmapped byte.
  task automatic check_defaults(input logic [6:0] addr);
    expect_eq({oe1, oe0, amp, spread}, {4'hE, pin}, "reset outputs");
    i_csp_host_model.read_block(addr, 8'h00, 3, q, racks);
    expect_eq(q[23:0], {16'h08FF, pin, 6'h06}, "reset readback");
    i_csp_host_model.read_block(addr, 8'h06, 3, q, racks);
    expect_eq(q[23:0], 24'h080008, "count default");
  endtask

  // A hang in the bus handshake ends the run as a failure.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    do_reset();
    check_defaults(A1);
    // Ordinary single-byte writes, each read back through a block read.
    for (int i = 0; i < 8; i++)
    begin
      i_csp_host_model.write_block(A1, ROWS[i].idx, 8'h01, {ROWS[i].data, 8'h00}, 1, wacks);
      expect_eq(wacks, 5'h0F, "write acks");
      expect_eq({oe1, oe0}, ROWS[i].oe, "enables");
      expect_eq(amp, ROWS[i].amp, "amplitude");
      expect_eq(spread, ROWS[i].spread, "spread");
      expect_eq(sda_out, 1'b0, "open drain level");
      i_csp_host_model.read_block(A1, ROWS[i].idx, 2, q, racks);
      expect_eq({racks, q[15:0]}, {3'h7, 8'h08, ROWS[i].rd}, "readback");
    end
    // Two bytes in one write land in consecutive registers.
    i_csp_host_model.write_block(A1, 8'h00, 8'h02, 16'h022B, 2, wacks);
    expect_eq({wacks, oe1, oe0, amp, spread}, {5'h1F, 6'h1D}, "block write");
    i_csp_host_model.read_block(A1, 8'h00, 3, q, racks);
    expect_eq(q[23:0], 24'h08FBEF, "block read");
    // A byte beyond the count is acknowledged but not stored.
    i_csp_host_model.write_block(A1, 8'h00, 8'h01, 16'h0600, 2, wacks);
    i_csp_host_model.read_block(A1, 8'h00, 3, q, racks);
    expect_eq({wacks, q[23:0]}, {5'h1F, 24'h08FFEF}, "beyond count");
    // The count field keeps its five bits; the upper three read zero.
    i_csp_host_model.write_block(A1, 8'h07, 8'h01, 16'hE300, 1, wacks);
    i_csp_host_model.read_block(A1, 8'h07, 2, q, racks);
    expect_eq(q[15:0], 16'h0303, "count write");
    // The other address is ignored for writes and reads.
    i_csp_host_model.write_block(A0, 8'h00, 8'h01, 16'h0000, 1, wacks);
    i_csp_host_model.read_block(A0, 8'h00, 2, q, racks);
    expect_eq({wacks, racks, oe1, oe0, q[15:0]}, {10'h003, 16'hFFFF}, "foreign address");
    // A second reset with the strap and spread pin changed.
    strap = 1'b0;
    pin = 2'h1;
    do_reset();
    check_defaults(A0);
    i_csp_host_model.write_block(A1, 8'h01, 8'h01, 16'h2000, 1, wacks);
    expect_eq({wacks, spread, amp}, {5'h00, 4'h6}, "old address after reset");
    i_csp_host_model.write_block(A0, 8'h01, 8'h01, 16'h2000, 1, wacks);
    expect_eq({wacks, spread, amp}, {5'h0F, 4'h0}, "new address after reset");
    // With the clock enable low the port must not see a whole write, so nothing is acknowledged or stored.
    ce = 1'b0;
    i_csp_host_model.write_block(A0, 8'h01, 8'h01, 16'h0300, 1, wacks);
    ce = 1'b1;
    repeat (10) @(negedge clk);
    expect_eq({wacks, spread, amp}, {5'h00, 4'h0}, "frozen by clock enable");
    print_verdict();
  end
endmodule // csp_smbus_port_test
